// ---- gigabit_autoneg_phy_pkg.sv ----
// package: offsets, field positions, reset values and state of the
// gigabit auto-negotiation register bank.
// assumes a 5-bit management register address and 16-bit registers.
package gigabit_autoneg_phy_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_EXPANSION = 5'h06;
   localparam logic [4:0] ADDR_NP_TX = 5'h07;
   localparam logic [4:0] ADDR_NP_RX = 5'h08;
   localparam logic [4:0] ADDR_GB_CTRL = 5'h09;
   localparam logic [4:0] ADDR_GB_STAT = 5'h0A;
   localparam logic [4:0] ADDR_GB_EXT = 5'h0F;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int EXP_PD_FAULT = 4;
   localparam int EXP_LP_NP = 3;
   localparam int EXP_LOC_NP = 2;
   localparam int EXP_PAGE_RX = 1;
   localparam int EXP_LP_AN = 0;
   localparam int NP_NEXT = 15;
   localparam int NP_MSG_PAGE = 13;
   localparam int NP_ACK2 = 12;
   localparam int NP_TOGGLE = 11;
   localparam int GC_TM_LSB = 13;
   localparam int GC_MANUAL = 12;
   localparam int GC_MS_VAL = 11;
   localparam int GC_PORT = 10;
   localparam int GC_ADV_FD = 9;
   localparam int GC_ADV_HD = 8;
   localparam int GS_MS_FAULT = 15;
   localparam int GS_MS_RES = 14;
   localparam int GS_LOC_RX = 13;
   localparam int GS_REM_RX = 12;
   localparam int GS_LP_FD = 11;
   localparam int GS_LP_HD = 10;

   // ----------------------------------------------------------------
   // reset and constant values
   // ----------------------------------------------------------------
   localparam logic [10:0] NP_MSG_RST = 11'h001;
   localparam logic NP_MSG_PAGE_RST = 1'b1;
   localparam logic LOC_NP_ABLE = 1'b1;
   localparam logic [2:0] TM_RST = 3'h0;
   localparam logic [7:0] IDLE_MSB_RST = 8'h00;
   localparam logic [15:0] IDLE_MAX = 16'hFFFF;
   localparam logic [15:0] GB_EXT_VAL = 16'h3000;

   // ----------------------------------------------------------------
   // test mode codes
   // ----------------------------------------------------------------
   localparam logic [2:0] TM_NORMAL = 3'h0;
   localparam logic [2:0] TM_JITTER = 3'h1;
   localparam logic [2:0] TM_JIT_MASTER = 3'h2;
   localparam logic [2:0] TM_JIT_SLAVE = 3'h3;
   localparam logic [2:0] TM_DISTORT = 3'h4;

   // ----------------------------------------------------------------
   // block state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] rdData;
      logic pdFault;
      logic lpNp;
      logic pageRx;
      logic lpAn;
      logic [15:0] rxWord;
      logic txNext;
      logic txMsgPage;
      logic txAck2;
      logic txToggle;
      logic [10:0] txMsg;
      logic [2:0] testMode;
      logic manual;
      logic msValue;
      logic portMulti;
      logic advFd;
      logic advHd;
      logic [7:0] ctrlResv;
      logic roleMaster;
      logic msFault;
      logic locRxOk;
      logic remRxOk;
      logic lpFd;
      logic lpHd;
      logic [15:0] idleCnt;
   } state_t;

endpackage : gigabit_autoneg_phy_pkg

// ---- gigabit_autoneg_phy_regs.sv ----
// module: management register bank for the auto-negotiation expansion,
// next-page, gigabit control/status and extended status registers.
// assumes core status inputs synchronous to mclk; one-cycle pulses for
// page arrival and idle errors.
`timescale 1ns/1ps

module gigabit_autoneg_phy_regs (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clkEn,
   // register port
   input wire logic [4:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdData,
   // negotiation status from the core
   input wire logic parDetFault,
   input wire logic lpNextPageAble,
   input wire logic lpAutonegAble,
   input wire logic pageReceived,
   input wire logic [15:0] rxCodeWord,
   input wire logic txAck2In,
   input wire logic txToggleIn,
   // gigabit status from the core
   input wire logic autoRoleMaster,
   input wire logic msConfigFault,
   input wire logic localRxOk,
   input wire logic remoteRxOk,
   input wire logic lpGigFullDuplex,
   input wire logic lpGigHalfDuplex,
   input wire logic idleError,
   // controls to the core
   output logic [15:0] txCodeWord,
   output logic [2:0] testMode,
   output logic manualRole,
   output logic roleMaster,
   output logic preferMultiPort,
   output logic advGigFullDuplex,
   output logic advGigHalfDuplex
);
   import gigabit_autoneg_phy_pkg::*;

   // ----------------------------------------------------------------
   // read-back decode
   // ----------------------------------------------------------------
   function automatic logic [15:0] regValue(input logic [4:0] a,
                                            input state_t s);
      logic [15:0] v;
      v = 16'h0000;
      unique case (a)
         ADDR_EXPANSION: begin
            v[EXP_PD_FAULT] = s.pdFault;
            v[EXP_LP_NP] = s.lpNp;
            v[EXP_LOC_NP] = LOC_NP_ABLE;
            v[EXP_PAGE_RX] = s.pageRx;
            v[EXP_LP_AN] = s.lpAn;
         end
         ADDR_NP_TX: begin
            v[NP_NEXT] = s.txNext;
            v[NP_MSG_PAGE] = s.txMsgPage;
            v[NP_ACK2] = s.txAck2;
            v[NP_TOGGLE] = s.txToggle;
            v[10:0] = s.txMsg;
         end
         ADDR_NP_RX: begin
            v = {1'b0, s.rxWord[14:0]};
         end
         ADDR_GB_CTRL: begin
            v[15:13] = s.testMode;
            v[GC_MANUAL] = s.manual;
            v[GC_MS_VAL] = s.msValue;
            v[GC_PORT] = s.portMulti;
            v[GC_ADV_FD] = s.advFd;
            v[GC_ADV_HD] = s.advHd;
            v[7:0] = s.ctrlResv;
         end
         ADDR_GB_STAT: begin
            v[GS_MS_FAULT] = s.msFault;
            v[GS_MS_RES] = s.roleMaster;
            v[GS_LOC_RX] = s.locRxOk;
            v[GS_REM_RX] = s.remRxOk;
            v[GS_LP_FD] = s.lpFd;
            v[GS_LP_HD] = s.lpHd;
            v[7:0] = s.idleCnt[15:8];
         end
         ADDR_GB_EXT: begin
            v = GB_EXT_VAL;
         end
         default: begin
            v = 16'h0000;
         end
      endcase
      return v;
   endfunction : regValue

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   state_t st_ff;
   state_t nxt_st;
   logic wrTx;
   logic wrCtrl;
   logic rdExp;

   assign wrTx = regWrite && (regAddr == ADDR_NP_TX);
   assign wrCtrl = regWrite && (regAddr == ADDR_GB_CTRL);
   assign rdExp = regRead && (regAddr == ADDR_EXPANSION);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rdData = 16'h0000;
      if (regRead) begin
         nxt_st.rdData = regValue(regAddr, st_ff);
      end
      nxt_st.pdFault = parDetFault;
      nxt_st.lpNp = lpNextPageAble;
      nxt_st.lpAn = lpAutonegAble;
      // a page arriving in the read cycle wins over the clear
      if (pageReceived) begin
         nxt_st.pageRx = 1'b1;
      end else if (rdExp) begin
         nxt_st.pageRx = 1'b0;
      end
      if (pageReceived) begin
         nxt_st.rxWord = rxCodeWord;
      end
      nxt_st.txAck2 = txAck2In;
      nxt_st.txToggle = txToggleIn;
      if (wrTx) begin
         nxt_st.txNext = regWrData[NP_NEXT];
         nxt_st.txMsgPage = regWrData[NP_MSG_PAGE];
         nxt_st.txMsg = regWrData[10:0];
      end
      if (wrCtrl) begin
         // reserved codes are stored as written
         nxt_st.testMode = regWrData[15:13];
         nxt_st.manual = regWrData[GC_MANUAL];
         nxt_st.msValue = regWrData[GC_MS_VAL];
         nxt_st.portMulti = regWrData[GC_PORT];
         nxt_st.advFd = regWrData[GC_ADV_FD];
         nxt_st.advHd = regWrData[GC_ADV_HD];
         nxt_st.ctrlResv = regWrData[7:0];
      end
      // role follows the control value in force now
      if (st_ff.manual) begin
         nxt_st.roleMaster = st_ff.msValue;
      end else begin
         nxt_st.roleMaster = autoRoleMaster;
      end
      nxt_st.msFault = msConfigFault;
      nxt_st.locRxOk = localRxOk;
      nxt_st.remRxOk = remoteRxOk;
      nxt_st.lpFd = lpGigFullDuplex;
      nxt_st.lpHd = lpGigHalfDuplex;
      // counter saturates instead of wrapping
      if (idleError && (st_ff.idleCnt != IDLE_MAX)) begin
         nxt_st.idleCnt = st_ff.idleCnt + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= '0;
         st_ff.txMsgPage <= NP_MSG_PAGE_RST;
         st_ff.txMsg <= NP_MSG_RST;
         st_ff.testMode <= TM_RST;
      end else if (clkEn) begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign regRdData = st_ff.rdData;
   assign txCodeWord = {st_ff.txNext, 1'b0, st_ff.txMsgPage, st_ff.txAck2,
                        st_ff.txToggle, st_ff.txMsg};
   assign testMode = st_ff.testMode;
   assign manualRole = st_ff.manual;
   assign roleMaster = st_ff.roleMaster;
   assign preferMultiPort = st_ff.portMulti;
   assign advGigFullDuplex = st_ff.advFd;
   assign advGigHalfDuplex = st_ff.advHd;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   sequence s_rd(logic [4:0] a);
      regRead && clkEn && (regAddr == a);
   endsequence

   sequence s_page_then_read;
      (pageReceived && clkEn) ##1 (s_rd(ADDR_EXPANSION) && !pageReceived);
   endsequence

   property p_exp_fault;
      s_rd(ADDR_EXPANSION) |=> regRdData[4] == $past(st_ff.pdFault);
   endproperty
   a_exp_fault: assert property (p_exp_fault)
      else $error("expansion fault bit wrong");

   property p_exp_partner;
      s_rd(ADDR_EXPANSION) |=> regRdData[3] == $past(st_ff.lpNp)
         && regRdData[0] == $past(st_ff.lpAn);
   endproperty
   a_exp_partner: assert property (p_exp_partner)
      else $error("partner ability bits wrong");

   property p_exp_const;
      s_rd(ADDR_EXPANSION) |=> regRdData[2] && regRdData[15:5] == 11'h000;
   endproperty
   a_exp_const: assert property (p_exp_const)
      else $error("expansion constant bits wrong");

   property p_page_seen;
      s_page_then_read |=> regRdData[1];
   endproperty
   a_page_seen: assert property (p_page_seen)
      else $error("page received not reported");

   property p_page_clear;
      s_page_then_read |=> !st_ff.pageRx;
   endproperty
   a_page_clear: assert property (p_page_clear)
      else $error("page flag not cleared by read");

   property p_rx_word;
      (pageReceived && clkEn) ##1 s_rd(ADDR_NP_RX)
         |=> regRdData[14:0] == $past(rxCodeWord[14:0], 2);
   endproperty
   a_rx_word: assert property (p_rx_word)
      else $error("received code word not mirrored");

   property p_tx_write;
      (regWrite && clkEn && regAddr == ADDR_NP_TX)
         |=> txCodeWord[10:0] == $past(regWrData[10:0])
         && txCodeWord[13] == $past(regWrData[13]) && !txCodeWord[14];
   endproperty
   a_tx_write: assert property (p_tx_write)
      else $error("transmit next page write lost");

   property p_test_mode;
      (regWrite && clkEn && regAddr == ADDR_GB_CTRL)
         |=> testMode == $past(regWrData[15:13])
         && preferMultiPort == $past(regWrData[10]);
   endproperty
   a_test_mode: assert property (p_test_mode)
      else $error("control write not applied");

   property p_manual_role;
      clkEn && st_ff.manual |=> roleMaster == $past(st_ff.msValue);
   endproperty
   a_manual_role: assert property (p_manual_role)
      else $error("manual role not forced");

   property p_auto_role;
      clkEn && !st_ff.manual |=> roleMaster == $past(autoRoleMaster);
   endproperty
   a_auto_role: assert property (p_auto_role)
      else $error("automatic role not followed");

   property p_rx_read;
      s_rd(ADDR_NP_RX) |=> regRdData == {1'b0, $past(st_ff.rxWord[14:0])};
   endproperty
   a_rx_read: assert property (p_rx_read)
      else $error("receive next page readback wrong");

   property p_tx_ro;
      s_rd(ADDR_NP_TX) |=> regRdData[12:11] == $past({st_ff.txAck2, st_ff.txToggle})
         && !regRdData[14];
   endproperty
   a_tx_ro: assert property (p_tx_ro)
      else $error("transmit read-only bits wrong");

   property p_ctrl_read;
      s_rd(ADDR_GB_CTRL) |=> regRdData[10] == $past(st_ff.portMulti)
         && regRdData[15:13] == $past(st_ff.testMode);
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("control readback wrong");

   property p_gstat_rx;
      s_rd(ADDR_GB_STAT) |=> regRdData[13:12] == $past({st_ff.locRxOk, st_ff.remRxOk});
   endproperty
   a_gstat_rx: assert property (p_gstat_rx)
      else $error("receiver status bits wrong");

   property p_gstat_lp;
      s_rd(ADDR_GB_STAT) |=> regRdData[11:10] == $past({st_ff.lpFd, st_ff.lpHd});
   endproperty
   a_gstat_lp: assert property (p_gstat_lp)
      else $error("partner gigabit ability bits wrong");

   property p_fault_live;
      clkEn |=> st_ff.pdFault == $past(parDetFault);
   endproperty
   a_fault_live: assert property (p_fault_live)
      else $error("parallel detection fault not tracked");

   property p_page_set;
      clkEn && pageReceived |=> st_ff.pageRx;
   endproperty
   a_page_set: assert property (p_page_set)
      else $error("page flag not set on arrival");

   property p_idle_step;
      clkEn && idleError && (st_ff.idleCnt != IDLE_MAX)
         |=> st_ff.idleCnt == $past(st_ff.idleCnt) + 16'h0001;
   endproperty
   a_idle_step: assert property (p_idle_step)
      else $error("idle error not counted");

   property p_gstat;
      s_rd(ADDR_GB_STAT) |=> regRdData[15:14] ==
         $past({st_ff.msFault, st_ff.roleMaster})
         && regRdData[9:8] == 2'h0 && regRdData[7:0] == $past(st_ff.idleCnt[15:8]);
   endproperty
   a_gstat: assert property (p_gstat)
      else $error("gigabit status readback wrong");

   property p_ext;
      s_rd(ADDR_GB_EXT) |=> regRdData == GB_EXT_VAL;
   endproperty
   a_ext: assert property (p_ext)
      else $error("extended status wrong");

endmodule : gigabit_autoneg_phy_regs

// ---- mgmt_host.sv ----
// partner model: station management host driving the register port.
// assumes a single mclk domain; read data stands one cycle after the strobe.
`timescale 1ns/1ps
module mgmt_host (
   // clock
   input wire logic mclk,
   // register port
   output logic [4:0] regAddr,
   output logic [15:0] regWrData,
   output logic regWrite,
   output logic regRead,
   input wire logic [15:0] regRdData
);
   import gigabit_autoneg_phy_pkg::*;

   initial begin
      regAddr = 5'h00;
      regWrData = 16'h0000;
      regWrite = 1'b0;
      regRead = 1'b0;
   end

   // -------------------------------------------------------------
   // single-cycle write strobe
   // -------------------------------------------------------------
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      // reserved test mode codes are never issued
      if (a == ADDR_GB_CTRL && d[15:13] > TM_DISTORT) begin
         return;
      end
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask : wr_reg

   // -------------------------------------------------------------
   // single-cycle read strobe, data taken in the following cycle
   // -------------------------------------------------------------
   task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      @(posedge mclk);
      d = regRdData;
   endtask : rd_reg
endmodule : mgmt_host

// ---- tb_top.sv ----
// testbench: register bank against a behavioural model of the registers.
// assumes mgmt_host as the management partner and clkEn tied high.
`timescale 1ns/1ps
module tb_top;
   import gigabit_autoneg_phy_pkg::*;
   logic mclk, reset_n;
   logic [4:0] regAddr;
   logic [15:0] regWrData, regRdData, rxCodeWord, txCodeWord, rdv;
   logic regWrite, regRead, parDetFault, lpNextPageAble, lpAutonegAble, pageReceived;
   logic txAck2In, txToggleIn, autoRoleMaster, msConfigFault, localRxOk, remoteRxOk;
   logic lpGigFullDuplex, lpGigHalfDuplex, idleError;
   logic [2:0] testMode;
   logic manualRole, roleMaster, preferMultiPort, advGigFullDuplex, advGigHalfDuplex;
   logic [15:0] mTx, mCtrl, mRx, mIdle;
   logic mPage;
   logic [31:0] rs = 32'h0000_0001;
   logic [2:0] tmTab[5] = '{TM_NORMAL, TM_JITTER, TM_JIT_MASTER, TM_JIT_SLAVE, TM_DISTORT};
   logic [4:0] addrs[8] = '{5'h00, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0F, 5'h1F};
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;

   gigabit_autoneg_phy_regs i_gigabit_autoneg_phy_regs (.mclk(mclk), .reset_n(reset_n),
      .clkEn(1'b1), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRead(regRead), .regRdData(regRdData), .parDetFault(parDetFault),
      .lpNextPageAble(lpNextPageAble), .lpAutonegAble(lpAutonegAble),
      .pageReceived(pageReceived), .rxCodeWord(rxCodeWord), .txAck2In(txAck2In),
      .txToggleIn(txToggleIn), .autoRoleMaster(autoRoleMaster), .msConfigFault(msConfigFault),
      .localRxOk(localRxOk), .remoteRxOk(remoteRxOk), .lpGigFullDuplex(lpGigFullDuplex),
      .lpGigHalfDuplex(lpGigHalfDuplex), .idleError(idleError), .txCodeWord(txCodeWord),
      .testMode(testMode), .manualRole(manualRole), .roleMaster(roleMaster),
      .preferMultiPort(preferMultiPort), .advGigFullDuplex(advGigFullDuplex),
      .advGigHalfDuplex(advGigHalfDuplex));

   mgmt_host i_mgmt_host (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));

   // -------------------------------------------------------------
   // clock, timeout, helpers
   // -------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : xs

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   function automatic logic [15:0] exp_read(input logic [4:0] a);
      logic role;
      role = mCtrl[12] ? mCtrl[11] : autoRoleMaster;
      case (a)
         5'h06: return {11'h000, parDetFault, lpNextPageAble, 1'b1, mPage, lpAutonegAble};
         5'h07: return {mTx[15], 1'b0, mTx[13], txAck2In, txToggleIn, mTx[10:0]};
         5'h08: return {1'b0, mRx[14:0]};
         5'h09: return mCtrl;
         5'h0A: return {msConfigFault, role, localRxOk, remoteRxOk, lpGigFullDuplex,
                        lpGigHalfDuplex, 2'b00, mIdle[15:8]};
         5'h0F: return 16'h3000;
         default: return 16'h0000;
      endcase
   endfunction : exp_read

   task automatic rd_chk(input logic [4:0] a);
      i_mgmt_host.rd_reg(a, rdv);
      check(rdv, exp_read(a));
      if (a == 5'h06) begin
         mPage = 1'b0;
      end
   endtask : rd_chk

   // page pulse with a read of a sampled in the very next cycle
   task automatic page_rd(input logic [4:0] a);
      logic [31:0] pr;
      pr = xs();
      @(posedge mclk);
      pageReceived <= 1'b1;
      rxCodeWord <= pr[15:0];
      mRx = pr[15:0];
      mPage = 1'b1;
      fork
         begin
            @(posedge mclk);
            pageReceived <= 1'b0;
         end
         rd_chk(a);
      join
   endtask : page_rd

   task automatic finish_test();
      $display("checks %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      logic [31:0] r;
      reset_n = 1'b0;
      {parDetFault, lpNextPageAble, lpAutonegAble, pageReceived, txAck2In, txToggleIn} = 6'h00;
      {autoRoleMaster, msConfigFault, localRxOk, remoteRxOk} = 4'h0;
      {lpGigFullDuplex, lpGigHalfDuplex, idleError} = 3'h0;
      rxCodeWord = 16'h0000;
      mTx = 16'h2001;
      mCtrl = 16'h0000;
      mRx = 16'h0000;
      mIdle = 16'h0000;
      mPage = 1'b0;
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      // reset values, unmapped addresses included
      check(txCodeWord, 16'h2001);
      foreach (addrs[i]) rd_chk(addrs[i]);
      $display("test reset values done");
      // random status, transmit word and control writes
      for (int i = 0; i < 25; i++) begin
         r = xs();
         @(posedge mclk);
         {parDetFault, lpNextPageAble, lpAutonegAble, autoRoleMaster, msConfigFault,
          localRxOk, remoteRxOk, lpGigFullDuplex, lpGigHalfDuplex, txAck2In,
          txToggleIn} <= r[10:0];
         mTx = r[31:16];
         i_mgmt_host.wr_reg(5'h07, mTx);
         r = xs();
         mCtrl = {tmTab[i % 5], r[12:0]};
         i_mgmt_host.wr_reg(5'h09, mCtrl);
         i_mgmt_host.wr_reg(5'h06, r[31:16]);
         i_mgmt_host.wr_reg(5'h0A, r[31:16]);
         repeat (4) @(posedge mclk);
         check(txCodeWord, exp_read(5'h07));
         check({13'h0000, testMode}, {13'h0000, mCtrl[15:13]});
         check({12'h000, manualRole, roleMaster, preferMultiPort, advGigFullDuplex},
               {12'h000, mCtrl[12], (mCtrl[12] ? mCtrl[11] : autoRoleMaster),
                mCtrl[10], mCtrl[9]});
         check({15'h0000, advGigHalfDuplex}, {15'h0000, mCtrl[8]});
         rd_chk(5'h06);
         rd_chk(5'h07);
         rd_chk(5'h09);
         rd_chk(5'h0A);
      end
      $display("test status and control done");
      // page arrival read back in the next cycle, mirror of the word, clear on read
      page_rd(5'h08);
      rd_chk(5'h08);
      page_rd(5'h06);
      rd_chk(5'h06);
      $display("test page received done");
      // idle error counter high byte
      repeat (600) begin
         @(posedge mclk);
         idleError <= 1'b1;
         @(posedge mclk);
         idleError <= 1'b0;
      end
      mIdle = 16'd600;
      repeat (3) @(posedge mclk);
      rd_chk(5'h0A);
      $display("test idle counter done");
      finish_test();
   end
endmodule : tb_top
